// [src/fcp_pkg.sv]
package fcp_pkg;
  // Wishbone word addresses (byte offset = 4 * index)
  localparam logic [7:0] ADR_CLKDIV  = 8'h00;
  localparam logic [7:0] ADR_SECURE  = 8'h01;
  localparam logic [7:0] ADR_CONFIG  = 8'h03;
  localparam logic [7:0] ADR_PROT    = 8'h04;
  localparam logic [7:0] ADR_STATUS  = 8'h05;
  localparam logic [7:0] ADR_CMD     = 8'h06;
  localparam logic [7:0] ADR_RSVD6   = 8'h07;
  localparam logic [7:0] ADR_ADDR    = 8'h08;
  localparam logic [7:0] ADR_DATA    = 8'h09;
  localparam logic [7:0] ADR_ARRAY   = 8'h0a;
  localparam logic [7:0] ADR_RSVD_LO = 8'h0b;
  localparam logic [7:0] ADR_RSVD_HI = 8'h0f;
  // Configuration fields
  localparam int CFG_BEIE  = 7;
  localparam int CFG_COMPLETE_IRQ_EN  = 6;
  localparam int CFG_KEYAC = 5;
  localparam logic [7:0] CFG_MASK = 8'he0;
  // Protection fields
  localparam int PR_OPEN  = 7;
  localparam int PR_HDIS  = 5;
  localparam int PR_HS_LO = 3;
  localparam int PR_LDIS  = 2;
  localparam int PR_LS_LO = 0;
  // Status fields
  localparam int ST_BEF   = 7;
  localparam int ST_CCF   = 6;
  localparam int ST_PROTECTION_VIOLATION_FLAG = 5;
  localparam int ST_ACCER = 4;
  // Security: key enable field [7:6], enabled code
  localparam logic [1:0] KEY_EN_CODE = 2'h2;
  localparam int SEC_KEY_LO = 6;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h41;
  localparam logic [7:0] CMD_PROGRAM    = 8'h20;
  localparam logic [15:0] HI_END   = 16'hffff;
  localparam logic [15:0] LO_START = 16'h4000;
  localparam logic [15:0] HI_SIZE0 = 16'h0800;
  localparam logic [15:0] LO_SIZE0 = 16'h0400;
  localparam logic [7:0]  ZERO8    = 8'h00;
  localparam logic [7:0]  DIV_MASK = 8'h3f;
  localparam int DIV_SET_BIT = 7;
  // Timebase ticks per command run, at least one
  localparam int CMD_TICKS  = 6;
  localparam int ROW_LSB    = 6;
endpackage : fcp_pkg

// [src/fcp_timebase.sv]
`timescale 1ns/1ps
module fcp_timebase (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [5:0] div_i,
  output logic            tick_o
);
  import fcp_pkg::*;
  typedef struct packed {
    logic [5:0] cnt;
    logic       tick;
  } fcp_tb_t;
  fcp_tb_t st_ff, nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt >= div_i) begin
      nxt_st.cnt  = 6'h00;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 6'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick_o = st_ff.tick;
endmodule : fcp_timebase

// [src/fcp_flash_ctrl.sv]
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
module fcp_flash_ctrl (
  input  wire logic        SYS_CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic        WB_WE_I,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic [7:0]  NV_PROT_I,
  input  wire logic [7:0]  NV_SEC_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             IRQ_O,
  output logic             HV_ON_O,
  output logic             BUSY_O
);
  import fcp_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_RUN} fcp_eng_t;

  typedef struct packed {
    logic        loaded;
    logic [7:0]  clkdiv;
    logic [7:0]  sec;
    logic [2:0]  cfg;
    logic [7:0]  prot;
    logic        bef;
    logic        protection_violation_flag;
    logic        access_error_flag;
    logic        staged;
    logic [7:0]  cmd0;
    logic [15:0] adr0;
    logic [15:0] dat0;
    logic        have_word;
    logic [7:0]  cmd1;
    logic [15:0] adr1;
    fcp_eng_t    eng;
    logic        busy;
    logic [3:0]  ticks;
    logic        hv;
    logic [31:0] rdat;
    logic        ack;
    logic        irq;
  } fcp_state_t;

  fcp_state_t st_ff, nxt_st;
  logic       tb_tick;
  logic       rst_n;
  logic [1:0] rst_sync_ff;

  // Assertion stays asynchronous; release reaches the state only after two
  // flops, so no state flop sees its reset lift close to a clock edge
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  fcp_timebase u_tb (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (rst_n),
    .div_i   (st_ff.clkdiv[5:0]),
    .tick_o  (tb_tick)
  );

  // Inclusive address span, shared by both protection ranges
  function automatic logic in_span(input logic [15:0] a, input logic [15:0] lo,
                                   input logic [15:0] hi);
    in_span = (a >= lo) && (a <= hi);
  endfunction : in_span

  function automatic logic in_protected(input logic [7:0] p, input logic [15:0] a);
    logic [15:0] hi_lo;
    logic [15:0] lo_hi;
    logic        in_hi;
    logic        in_lo;
    hi_lo = HI_END - ((HI_SIZE0 << p[PR_HS_LO +: 2]) - 16'h0001);
    lo_hi = LO_START + ((LO_SIZE0 << p[PR_LS_LO +: 2]) - 16'h0001);
    in_hi = in_span(a, hi_lo, HI_END);
    in_lo = in_span(a, LO_START, lo_hi);
    if (p[PR_OPEN]) begin
      in_protected = (in_hi && !p[PR_HDIS]) || (in_lo && !p[PR_LDIS]);
    end else begin
      in_protected = !((in_hi && !p[PR_HDIS]) || (in_lo && !p[PR_LDIS]));
    end
  endfunction : in_protected

  function automatic logic any_protection(input logic [7:0] p);
    any_protection = !p[PR_OPEN] || !p[PR_HDIS] || !p[PR_LDIS];
  endfunction : any_protection

  // Complete means nothing buffered and nothing running
  function automatic logic [7:0] status_word(input fcp_state_t s);
    status_word           = ZERO8;
    status_word[ST_BEF]   = s.bef;
    status_word[ST_CCF]   = s.bef && !s.busy;
    status_word[ST_PROTECTION_VIOLATION_FLAG] = s.protection_violation_flag;
    status_word[ST_ACCER] = s.access_error_flag;
  endfunction : status_word

  // Launch needs a full staged triple and no pending error
  function automatic logic launch_ok(input fcp_state_t s);
    launch_ok = s.have_word && s.staged && !s.protection_violation_flag && !s.access_error_flag;
  endfunction : launch_ok

  // Array word refused before divider set, while buffer full or word pending
  function automatic logic array_refused(input fcp_state_t s);
    array_refused = !s.clkdiv[DIV_SET_BIT] || !s.bef || s.have_word;
  endfunction : array_refused

  logic       wr;
  logic       rd;
  logic [7:0] wd;

  always_comb begin
    wr = WB_CYC_I && WB_STB_I && WB_WE_I && !st_ff.ack && WB_SEL_I[0];
    rd = WB_CYC_I && WB_STB_I && !WB_WE_I && !st_ff.ack;
    wd = WB_DAT_I[7:0];
    nxt_st = st_ff;
    nxt_st.ack = WB_CYC_I && WB_STB_I && !st_ff.ack;
    nxt_st.rdat = 32'h0000_0000;

    if (!st_ff.loaded) begin
      nxt_st.loaded = 1'b1;
      nxt_st.prot   = NV_PROT_I;
      nxt_st.sec    = NV_SEC_I;
    end

    if (rd) begin
      case (WB_ADR_I)
        ADR_CLKDIV: nxt_st.rdat[7:0] = st_ff.clkdiv;
        ADR_SECURE: nxt_st.rdat[7:0] = st_ff.sec;
        ADR_CONFIG: nxt_st.rdat[7:0] = {st_ff.cfg, 5'h00};
        ADR_PROT:   nxt_st.rdat[7:0] = st_ff.prot;
        ADR_STATUS: nxt_st.rdat[7:0] = status_word(st_ff);
        ADR_CMD:    nxt_st.rdat[7:0] = st_ff.cmd0;
        ADR_ADDR:   nxt_st.rdat[15:0] = st_ff.adr0;
        ADR_DATA:   nxt_st.rdat[15:0] = st_ff.dat0;
        // Key mode hides array content; real array read is outside
        ADR_ARRAY:  nxt_st.rdat = st_ff.cfg[0] ? 32'hdead_dead : 32'h0000_0000;
        default:    nxt_st.rdat = 32'h0000_0000;
      endcase
    end

    if (wr) begin
      case (WB_ADR_I)
        ADR_CLKDIV: begin
          if (!st_ff.clkdiv[DIV_SET_BIT]) begin
            nxt_st.clkdiv = {1'b1, 1'b0, wd[5:0] & DIV_MASK[5:0]};
          end
        end
        ADR_CONFIG: begin
          nxt_st.cfg[2:1] = wd[CFG_BEIE -: 2];
          if (st_ff.sec[SEC_KEY_LO +: 2] == KEY_EN_CODE) begin
            nxt_st.cfg[0] = wd[CFG_KEYAC];
          end
        end
        ADR_PROT: begin
          nxt_st.prot[PR_OPEN] = st_ff.prot[PR_OPEN] & wd[PR_OPEN];
          nxt_st.prot[PR_HDIS] = st_ff.prot[PR_HDIS] & wd[PR_HDIS];
          nxt_st.prot[PR_LDIS] = st_ff.prot[PR_LDIS] & wd[PR_LDIS];
          if (st_ff.prot[PR_HDIS]) begin
            nxt_st.prot[PR_HS_LO +: 2] = wd[PR_HS_LO +: 2];
          end
          if (st_ff.prot[PR_LDIS]) begin
            nxt_st.prot[PR_LS_LO +: 2] = wd[PR_LS_LO +: 2];
          end
        end
        ADR_STATUS: begin
          if (wd[ST_PROTECTION_VIOLATION_FLAG]) nxt_st.protection_violation_flag = 1'b0;
          if (wd[ST_ACCER]) nxt_st.access_error_flag = 1'b0;
          // Launch: writing one to buffer-empty flag commits staged command
          if (wd[ST_BEF] && launch_ok(st_ff)) begin
            nxt_st.bef       = 1'b0;
            nxt_st.have_word = 1'b0;
            nxt_st.staged    = 1'b0;
          end
        end
        ADR_CMD: begin
          if (st_ff.have_word && !st_ff.staged) begin
            if (wd == CMD_MASS_ERASE && any_protection(st_ff.prot)) begin
              nxt_st.protection_violation_flag     = 1'b1;
              nxt_st.have_word = 1'b0;
            end else begin
              nxt_st.cmd0   = wd;
              nxt_st.staged = 1'b1;
            end
          end else begin
            nxt_st.access_error_flag    = 1'b1;
            nxt_st.have_word = 1'b0;
          end
        end
        ADR_ARRAY: begin
          if (st_ff.cfg[0]) begin
            nxt_st.have_word = 1'b0;
          end else if (array_refused(st_ff)) begin
            nxt_st.access_error_flag    = 1'b1;
            nxt_st.have_word = 1'b0;
          end else if (in_protected(st_ff.prot, WB_DAT_I[31:16])) begin
            nxt_st.protection_violation_flag     = 1'b1;
          end else begin
            nxt_st.adr0      = WB_DAT_I[31:16];
            nxt_st.dat0      = WB_DAT_I[15:0];
            nxt_st.have_word = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // Engine: second stage of the queue
    case (st_ff.eng)
      S_IDLE: begin
        nxt_st.hv = 1'b0;
        if (!st_ff.bef) begin
          nxt_st.cmd1  = st_ff.cmd0;
          nxt_st.adr1  = st_ff.adr0;
          nxt_st.bef   = 1'b1;
          nxt_st.ticks = 4'h0;
          nxt_st.hv    = 1'b1;
          nxt_st.eng   = S_RUN;
        end
      end
      S_RUN: begin
        if (tb_tick) begin
          nxt_st.ticks = st_ff.ticks + 4'h1;
        end
        if (tb_tick && st_ff.ticks == 4'(CMD_TICKS - 1)) begin
          if (!st_ff.bef && !nxt_st.bef) begin
            nxt_st.cmd1  = st_ff.cmd0;
            nxt_st.adr1  = st_ff.adr0;
            nxt_st.bef   = 1'b1;
            nxt_st.ticks = 4'h0;
            // Same-row program keeps the pump up
            nxt_st.hv = (st_ff.cmd0 == CMD_PROGRAM) && (st_ff.cmd1 == CMD_PROGRAM)
                        && (st_ff.adr0[15:ROW_LSB] == st_ff.adr1[15:ROW_LSB]);
            nxt_st.eng = S_RUN;
          end else begin
            nxt_st.hv  = 1'b0;
            nxt_st.eng = S_IDLE;
          end
        end
      end
      default: nxt_st.eng = S_IDLE;
    endcase
    nxt_st.busy = (nxt_st.eng != S_IDLE);

    nxt_st.irq = (nxt_st.cfg[2] && nxt_st.bef)
               || (nxt_st.cfg[1] && nxt_st.bef && nxt_st.eng == S_IDLE);
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      st_ff     <= '0;
      st_ff.bef <= 1'b1;
      st_ff.eng <= S_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign WB_DAT_O = st_ff.rdat;
  assign WB_ACK_O = st_ff.ack;
  assign IRQ_O    = st_ff.irq;
  assign HV_ON_O  = st_ff.hv;
  assign BUSY_O   = st_ff.busy;
endmodule : fcp_flash_ctrl

// [test/fcp_props.sv]
`timescale 1ns/1ps
module fcp_props (
  input wire logic        SYS_CLK_I,
  input wire logic        RESET_N_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic        WB_WE_I,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        IRQ_O
);
  import fcp_pkg::*;
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  logic rd_ack;
  logic open_clr_ff;
  assign rd_ack = WB_ACK_O && !WB_WE_I;
  sequence take_s; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
  sequence pulse_s; WB_ACK_O ##1 !WB_ACK_O; endsequence
  // Remembers a seen clear of the open bit; it may never come back
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) open_clr_ff <= 1'b0;
    else if (rd_ack && WB_ADR_I == ADR_PROT && !WB_DAT_O[PR_OPEN]) open_clr_ff <= 1'b1;
  end
  AST_ACK_TAKE: assert property (take_s |=> pulse_s) else $error("ack not one cycle pulse");
  AST_ACK_CAUSE: assert property ($rose(WB_ACK_O) |-> $past(WB_STB_I) && $past(WB_CYC_I))
    else $error("ack without request");
  AST_NO_ACK_IDLE: assert property (!WB_CYC_I |-> !WB_ACK_O) else $error("ack while idle");
  AST_RSVD6: assert property (rd_ack && WB_ADR_I == ADR_RSVD6 |-> WB_DAT_O == 32'h0)
    else $error("reserved six not zero");
  AST_RSVD_HI: assert property (rd_ack && WB_ADR_I inside {[ADR_RSVD_LO:ADR_RSVD_HI]}
    |-> WB_DAT_O == 32'h0) else $error("reserved slot not zero");
  AST_CFG_BITS: assert property (rd_ack && WB_ADR_I == ADR_CONFIG
    |-> (WB_DAT_O & ~{24'h0, CFG_MASK}) == 32'h0) else $error("config spare bits set");
  AST_OPEN_STICKY: assert property (rd_ack && WB_ADR_I == ADR_PROT && open_clr_ff
    |-> !WB_DAT_O[PR_OPEN]) else $error("open bit set again");
  AST_IRQ_OFF: assert property (rd_ack && WB_ADR_I == ADR_CONFIG
    && WB_DAT_O[CFG_BEIE:CFG_COMPLETE_IRQ_EN] == 2'b00 |-> !IRQ_O) else $error("irq while disabled");
endmodule : fcp_props
bind fcp_flash_ctrl fcp_props u_props (.SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I),
  .WB_ADR_I(WB_ADR_I), .WB_WE_I(WB_WE_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .IRQ_O(IRQ_O));

// [test/fcp_host_model.sv]
`timescale 1ns/1ps
module fcp_host_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic [7:0]       adr_o,
  output logic [31:0]      dat_o,
  output logic [3:0]       sel_o,
  output logic             we_o,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             hung_o
);
  initial begin
    {adr_o, dat_o, sel_o, we_o, cyc_o, stb_o, hung_o} = '0;
  end
  task xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    adr_o <= a;
    dat_o <= d;
    we_o  <= we;
    sel_o <= 4'hf;
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 50);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // Released data lines flip so stale values never look valid
    dat_o <= ~d;
    if (n >= 50) hung_o <= 1'b1;
  endtask : xfer
endmodule : fcp_host_model

// [test/fcp_flash_ctrl_tb_top.sv]
`timescale 1ns/1ps
module fcp_flash_ctrl_tb_top;
  import fcp_pkg::*;
  logic        clk, rst_n, we, cyc, stb, ack, irq, hv, busy, hung;
  logic [7:0]  adr, nv_prot, nv_sec;
  logic [31:0] wdat, rdat, q;
  logic [3:0]  sel;
  int          fails, n_tests;
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  fcp_host_model host (.clk_i(clk), .ack_i(ack), .dat_i(rdat), .adr_o(adr), .dat_o(wdat),
    .sel_o(sel), .we_o(we), .cyc_o(cyc), .stb_o(stb), .hung_o(hung));
  fcp_flash_ctrl dut (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .WB_ADR_I(adr), .WB_DAT_I(wdat),
    .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .NV_PROT_I(nv_prot),
    .NV_SEC_I(nv_sec), .WB_DAT_O(rdat), .WB_ACK_O(ack), .IRQ_O(irq), .HV_ON_O(hv),
    .BUSY_O(busy));
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task end_of_test;
    $display("fails %0d n_tests %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  always @(posedge hung) begin
    fails++;
    end_of_test;
  end
  task wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask : wr
  task rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, q);
  endtask : rd
  task do_reset(input logic [7:0] sec);
    nv_sec <= sec;
    rst_n  <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : do_reset
  task t_cfg(input logic key);
    wr(ADR_CONFIG, 32'hff);
    rd(ADR_CONFIG);
    chk("config", 32'(q[7:0]), key ? 32'he0 : 32'hc0);
    if (key) begin
      rd(ADR_ARRAY);
      chk("key read", q, 32'hdeaddead);
    end
    wr(ADR_CONFIG, 32'h0);
  endtask : t_cfg
  task t_rsvd;
    for (int i = 7; i < 16; i++) begin
      if (i == 7 || i > 10) begin
        wr(8'(i), 32'hffffffff);
        rd(8'(i));
        chk("reserved", q, 32'h0);
      end
    end
  endtask : t_rsvd
  task t_irq(input logic [7:0] cfg, input logic exp);
    wr(ADR_CONFIG, 32'(cfg));
    repeat (2) @(posedge clk);
    chk("irq", 32'(irq), 32'(exp));
  endtask : t_irq
  task t_prot;
    logic [7:0] w[6] = '{8'h3f, 8'hbf, 8'h39, 8'h3a, 8'h01, 8'h19};
    logic [7:0] e[6] = '{8'h3f, 8'h3f, 8'h39, 8'h39, 8'h01, 8'h01};
    rd(ADR_PROT);
    chk("prot load", 32'(q[7:0]), 32'hbf);
    for (int i = 0; i < 6; i++) begin
      wr(ADR_PROT, 32'(w[i]));
      rd(ADR_PROT);
      chk("prot", 32'(q[7:0]), 32'(e[i]));
    end
  endtask : t_prot
  task launch(input logic [31:0] ad, input logic [7:0] cmd);
    wr(ADR_ARRAY, ad);
    wr(ADR_CMD, 32'(cmd));
  endtask : launch
  task t_cmd;
    int   n;
    logic hv_drop;
    wr(ADR_ARRAY, 32'h40000001);
    rd(ADR_STATUS);
    chk("access_error_flag", 32'(q[ST_ACCER]), 32'h1);
    wr(ADR_STATUS, 32'h10);
    wr(ADR_CLKDIV, 32'h81);
    launch(32'h40000011, CMD_PROGRAM);
    wr(ADR_STATUS, 32'h80);
    launch(32'h40020022, CMD_PROGRAM);
    wr(ADR_STATUS, 32'h80);
    chk("busy", 32'(busy), 32'h1);
    n       = 0;
    hv_drop = 1'b0;
    while (busy === 1'b1 && n < 400) begin
      if (hv !== 1'b1) hv_drop = 1'b1;
      @(posedge clk);
      n++;
    end
    chk("idle", 32'(busy), 32'h0);
    if (busy !== 1'b0) end_of_test;
    // Rest of the first command plus the full run of the queued one
    chk("run", 32'(n >= CMD_TICKS * 2 && n <= CMD_TICKS * 4), 32'h1);
    chk("hv kept", 32'(hv_drop), 32'h0);
    chk("hv off", 32'(hv), 32'h0);
    rd(ADR_STATUS);
    chk("errors", 32'(q[ST_PROTECTION_VIOLATION_FLAG:ST_ACCER]), 32'h0);
    wr(ADR_ARRAY, 32'h48000000);
    rd(ADR_STATUS);
    chk("range", 32'(q[ST_PROTECTION_VIOLATION_FLAG]), 32'h1);
    wr(ADR_STATUS, 32'h20);
    launch(32'h40000000, CMD_MASS_ERASE);
    rd(ADR_STATUS);
    chk("protection_violation_flag", 32'(q[ST_PROTECTION_VIOLATION_FLAG]), 32'h1);
    // Stage a legal command so only the violation can hold it back
    launch(32'h40000040, CMD_PROGRAM);
    wr(ADR_STATUS, 32'h80);
    repeat (3) @(posedge clk);
    chk("locked", 32'(busy), 32'h0);
    wr(ADR_STATUS, 32'h20);
    rd(ADR_STATUS);
    chk("protection_violation_flag clr", 32'(q[ST_PROTECTION_VIOLATION_FLAG]), 32'h0);
    wr(ADR_STATUS, 32'h80);
    repeat (2) @(posedge clk);
    chk("unlocked", 32'(busy), 32'h1);
  endtask : t_cmd
  initial begin
    rst_n   = 1'b0;
    nv_prot = 8'hbf;
    nv_sec  = 8'h0;
    fails   = 0;
    n_tests = 0;
    do_reset(8'h0);
    t_prot;
    t_cfg(1'b0);
    t_rsvd;
    t_irq(8'h00, 1'b0);
    t_irq(8'h80, 1'b1);
    t_irq(8'h40, 1'b1);
    t_irq(8'h00, 1'b0);
    t_cmd;
    do_reset({KEY_EN_CODE, 6'h0});
    t_cfg(1'b1);
    end_of_test;
  end
endmodule : fcp_flash_ctrl_tb_top
